/* File: cod_decode.sv */
// Purpose: opcode decoder with cycle counts and bus control
// Assumes: opcode and flags presented together with op_valid
// Notes:   decode result appears one clock after op_valid
`default_nettype none

module cod_decode
    import cod_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // instruction in
    input  wire logic        op_valid,
    input  wire logic [7:0]  opcode,
    input  wire cod_flags_s  flags,
    // decode out
    output logic             dec_valid_reg,
    output cod_decode_s      dec_reg,
    // bus access request
    input  wire logic        acc_req,
    input  wire logic        acc_write,
    input  wire logic        ready,
    input  wire logic        hold_req,
    // bus pins
    output logic             rd_strobe_reg,
    output logic             wr_strobe_reg,
    output logic             bus_oe_reg,
    output logic             hold_ack_reg,
    output logic             acc_done_reg
);

    logic        cond_met;
    cod_decode_s dec_next;

    ////////////////////////////////////////////////////////////////
    // memory operand test, used by copy and accumulator forms
    function automatic logic is_mem(input logic [2:0] f);
        // code 110 is the hl memory operand
        is_mem = (f == REG_MEM);
    endfunction : is_mem

    // pick one of two counts by condition outcome
    function automatic logic [4:0] pick(input logic t,
                                        input logic [4:0] lo,
                                        input logic [4:0] hi);
        pick = t ? hi : lo;
    endfunction : pick

    // full opcode decode
    function automatic cod_decode_s decode(input logic [7:0] o,
                                           input logic       met);
        cod_decode_s d;
        d           = '0;
        d.op        = OP_NONE;
        d.dst       = o[5:3];
        d.src       = o[2:0];
        d.pair      = o[5:4];
        d.alu       = o[5:3];
        d.rot       = o[4:3];
        d.cond      = o[5:3];
        casez (o)
            // stack top swap and hl to sp
            8'b11100011: begin
                d.op     = OP_STK_HL_SWAP;
                d.cycles = CYC_16;
            end
            8'b11111001: begin
                d.op     = OP_HL_TO_SP;
                d.cycles = CYC_6;
            end
            8'b11101011: begin
                d.op     = OP_DE_HL_SWAP;
                d.cycles = CYC_4;
            end
            8'b11000011: begin
                d.op     = OP_JUMP;
                d.taken  = 1'b1;
                d.cycles = CYC_10;
            end
            8'b11001101: begin
                d.op      = OP_CALL;
                d.taken   = 1'b1;
                d.push_pc = 1'b1;
                d.cycles  = CYC_18;
            end
            8'b11001001: begin
                d.op     = OP_RETURN;
                d.taken  = 1'b1;
                d.cycles = CYC_10;
            end
            8'b11101001: begin
                d.op     = OP_HL_TO_PC;
                d.taken  = 1'b1;
                d.cycles = CYC_6;
            end
            8'b01??????: begin
                if (o != 8'h76) begin
                    d.op     = OP_REG_COPY;
                    d.cycles = (is_mem(o[5:3]) || is_mem(o[2:0])) ? CYC_7 : CYC_4;
                end
            end
            8'b00??0001: begin
                d.op     = OP_PAIR_IMM;
                d.cycles = CYC_10;
            end
            // push, code 11 is A plus flags
            8'b11??0101: begin
                d.op      = OP_PUSH;
                d.psw_sel = (o[5:4] == PAIR_LAST);
                d.cycles  = CYC_12;
            end
            8'b11??0001: begin
                d.op      = OP_POP;
                d.psw_sel = (o[5:4] == PAIR_LAST);
                d.cycles  = CYC_10;
            end
            8'b00??0011: begin
                d.op     = OP_PAIR_INC;
                d.cycles = CYC_6;
            end
            8'b00??1011: begin
                d.op     = OP_PAIR_DEC;
                d.cycles = CYC_6;
            end
            8'b00??1001: begin
                d.op     = OP_PAIR_SUM;
                d.cycles = CYC_10;
            end
            8'b10??????: begin
                d.op     = OP_ALU_REG;
                d.cycles = is_mem(o[2:0]) ? CYC_7 : CYC_4;
            end
            8'b11???110: begin
                d.op     = OP_ALU_IMM;
                d.cycles = CYC_7;
            end
            8'b000??111: begin
                d.op     = OP_ROTATE;
                d.cycles = CYC_4;
            end
            8'b11???010: begin
                d.op        = OP_JUMP;
                d.cond_used = 1'b1;
                d.taken     = met;
                d.cycles    = pick(met, CYC_7, CYC_10);
            end
            8'b11???100: begin
                d.op        = OP_CALL;
                d.cond_used = 1'b1;
                d.taken     = met;
                d.push_pc   = met;
                d.cycles    = pick(met, CYC_9, CYC_18);
            end
            8'b11???000: begin
                d.op        = OP_RETURN;
                d.cond_used = 1'b1;
                d.taken     = met;
                d.cycles    = pick(met, CYC_6, CYC_12);
            end
            8'b11???111: begin
                d.op      = OP_RESTART;
                d.taken   = 1'b1;
                d.push_pc = 1'b1;
                d.vector  = {10'h000, o[5:3], 3'h0};
                d.cycles  = CYC_12;
            end
            default: d.op = OP_NONE;
        endcase
        return d;
    endfunction : decode

    ////////////////////////////////////////////////////////////////
    // condition test on bits 5..3
    cod_cond_eval u_cond (
        .cond  (opcode[5:3]),
        .flags (flags),
        .met   (cond_met)
    );

    assign dec_next = decode(opcode, cond_met);

    // decode register, held until the next opcode
    always_ff @(posedge clock) begin
        if (rst) begin
            dec_valid_reg <= 1'b0;
            dec_reg       <= '0;
        end else begin
            dec_valid_reg <= op_valid;
            if (op_valid)
                dec_reg <= dec_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // bus strobe stretch and release
    cod_bus_ctrl u_bus (
        .clock         (clock),
        .rst           (rst),
        .acc_req       (acc_req),
        .acc_write     (acc_write),
        .ready         (ready),
        .hold_req      (hold_req),
        .rd_strobe_reg (rd_strobe_reg),
        .wr_strobe_reg (wr_strobe_reg),
        .bus_oe_reg    (bus_oe_reg),
        .hold_ack_reg  (hold_ack_reg),
        .acc_done_reg  (acc_done_reg)
    );

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_copy_cycles: assert property (
        op_valid && opcode[7:6] == 2'b01 && opcode != 8'h76 |=>
        dec_reg.op == OP_REG_COPY &&
        dec_reg.cycles == (($past(opcode[5:3]) == 3'h6 ||
                            $past(opcode[2:0]) == 3'h6) ? 5'h07 : 5'h04))
        else $error("copy cycle count wrong");

    a_push_psw_sel: assert property (
        op_valid && opcode == 8'hf5 |=>
        dec_reg.op == OP_PUSH && dec_reg.psw_sel && dec_reg.cycles == 5'h0c)
        else $error("push of A and flags misdecoded");

    a_pop_pair: assert property (
        op_valid && opcode[7:6] == 2'b11 && opcode[3:0] == 4'h1 |=>
        dec_reg.op == OP_POP && dec_reg.pair == $past(opcode[5:4]) &&
        dec_reg.cycles == 5'h0a)
        else $error("pop misdecoded");

    a_stk_swap: assert property (
        op_valid && opcode == 8'he3 |=> dec_reg.cycles == 5'h10)
        else $error("stack swap count wrong");

    a_alu_mem: assert property (
        op_valid && opcode[7:6] == 2'b10 |=>
        dec_reg.alu == $past(opcode[5:3]) &&
        dec_reg.cycles == ($past(opcode[2:0]) == 3'h6 ? 5'h07 : 5'h04))
        else $error("accumulator op misdecoded");

    a_jump_cond: assert property (
        op_valid && opcode[7:6] == 2'b11 && opcode[2:0] == 3'h2 |=>
        dec_reg.cycles == (dec_reg.taken ? 5'h0a : 5'h07) &&
        dec_reg.taken == $past(cond_met))
        else $error("conditional jump count wrong");

    a_call_cond: assert property (
        op_valid && opcode[7:6] == 2'b11 && opcode[2:0] == 3'h4 |=>
        dec_reg.cycles == (dec_reg.taken ? 5'h12 : 5'h09))
        else $error("conditional call count wrong");

    a_zero_test: assert property (
        op_valid && opcode[5:3] == 3'h1 && opcode[7:6] == 2'b11 &&
        opcode[2:0] == 3'h0 |=> dec_reg.taken == $past(flags.zero))
        else $error("zero condition wrong");

    a_restart_vec: assert property (
        op_valid && opcode[7:6] == 2'b11 && opcode[2:0] == 3'h7 |=>
        dec_reg.vector == {10'h000, $past(opcode[5:3]), 3'h0} &&
        dec_reg.push_pc && dec_reg.cycles == 5'h0c)
        else $error("restart vector wrong");

    a_strobe_held: assert property (
        (rd_strobe_reg || wr_strobe_reg) && !ready |=>
        $stable(rd_strobe_reg) && $stable(wr_strobe_reg))
        else $error("strobe dropped before ready");

    a_strobe_ends: assert property (
        (rd_strobe_reg || wr_strobe_reg) && ready |=>
        !rd_strobe_reg && !wr_strobe_reg && acc_done_reg)
        else $error("strobe not ended on ready");

    a_hold_float: assert property (
        hold_req && !rd_strobe_reg && !wr_strobe_reg |=>
        !bus_oe_reg && hold_ack_reg)
        else $error("bus not released on hold");

    a_no_float_busy: assert property (
        rd_strobe_reg || wr_strobe_reg |-> bus_oe_reg)
        else $error("bus floated during access");

    c_mem_copy:   cover property (op_valid && opcode == 8'h7e);
    c_call_taken: cover property (op_valid && opcode == 8'hcc ##1 dec_reg.taken);
    c_wait_state: cover property (rd_strobe_reg && !ready ##1 rd_strobe_reg && ready);
    c_hold_cycle: cover property (hold_req ##1 hold_ack_reg ##1 !hold_req);

endmodule : cod_decode

`default_nettype wire

/* File: cod_pkg.sv */
// Purpose: shared types and constants for the opcode decoder
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes:   cycle counts are processor clock states, not local cycles
`default_nettype none

package cod_pkg;

    ////////////////////////////////////////////////////////////////
    // operation classes
    typedef enum logic [4:0] {
        OP_NONE         = 5'h00,
        OP_REG_COPY     = 5'h01,
        OP_PAIR_IMM     = 5'h02,
        OP_PUSH         = 5'h03,
        OP_POP          = 5'h04,
        OP_STK_HL_SWAP  = 5'h05,
        OP_HL_TO_SP     = 5'h06,
        OP_DE_HL_SWAP   = 5'h07,
        OP_PAIR_INC     = 5'h08,
        OP_PAIR_DEC     = 5'h09,
        OP_PAIR_SUM     = 5'h0a,
        OP_ALU_REG      = 5'h0b,
        OP_ALU_IMM      = 5'h0c,
        OP_ROTATE       = 5'h0d,
        OP_JUMP         = 5'h0e,
        OP_CALL         = 5'h0f,
        OP_RETURN       = 5'h10,
        OP_RESTART      = 5'h11,
        OP_HL_TO_PC     = 5'h12
    } cod_op_e;

    // register field codes
    localparam logic [2:0] REG_MEM   = 3'h6;
    localparam logic [1:0] PAIR_LAST = 2'h3;   // sp or accumulator_flags_word

    // clock-state counts
    localparam logic [4:0] CYC_4  = 5'h04;
    localparam logic [4:0] CYC_6  = 5'h06;
    localparam logic [4:0] CYC_7  = 5'h07;
    localparam logic [4:0] CYC_9  = 5'h09;
    localparam logic [4:0] CYC_10 = 5'h0a;
    localparam logic [4:0] CYC_12 = 5'h0c;
    localparam logic [4:0] CYC_16 = 5'h10;
    localparam logic [4:0] CYC_18 = 5'h12;

    // processor condition flags
    typedef struct packed {
        logic sign;
        logic zero;
        logic parity;
        logic carry;
    } cod_flags_s;

    // decoded instruction
    typedef struct packed {
        cod_op_e     op;
        logic [2:0]  dst;
        logic [2:0]  src;
        logic [1:0]  pair;
        logic        psw_sel;
        logic [2:0]  alu;
        logic [1:0]  rot;
        logic [2:0]  cond;
        logic        cond_used;
        logic        taken;
        logic        push_pc;
        logic [4:0]  cycles;
        logic [15:0] vector;
    } cod_decode_s;

endpackage : cod_pkg

`default_nettype wire

/* File: cod_cond_eval.sv */
// Purpose: evaluate a three-bit condition code against the flags
// Assumes: flags are valid in the cycle the code is presented
// Notes:   purely combinational, registered by the caller
`default_nettype none

module cod_cond_eval
    import cod_pkg::*;
(
    // condition request
    input  wire logic [2:0] cond,
    input  wire cod_flags_s flags,
    // result
    output logic            met
);

    ////////////////////////////////////////////////////////////////
    // eight condition tests
    always_comb begin
        unique case (cond)
            3'h0: met = !flags.zero;
            3'h1: met = flags.zero;
            3'h2: met = !flags.carry;
            3'h3: met = flags.carry;
            3'h4: met = !flags.parity;   // parity odd
            3'h5: met = flags.parity;    // parity even
            3'h6: met = !flags.sign;     // plus
            3'h7: met = flags.sign;      // minus
        endcase
    end

endmodule : cod_cond_eval

`default_nettype wire

/* File: cod_bus_ctrl.sv */
// Purpose: read/write strobe stretching and bus release on hold
// Assumes: requests and ready are synchronous to clock
// Notes:   requests arriving while busy or held are served at idle if kept asserted
`default_nettype none

module cod_bus_ctrl
    import cod_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // access request
    input  wire logic acc_req,
    input  wire logic acc_write,
    input  wire logic ready,
    input  wire logic hold_req,
    // bus side
    output logic      rd_strobe_reg,
    output logic      wr_strobe_reg,
    output logic      bus_oe_reg,
    output logic      hold_ack_reg,
    output logic      acc_done_reg
);

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b00,
        BUS_ACCESS = 2'b01,
        BUS_HOLD   = 2'b10
    } cod_bus_e;

    cod_bus_e state_reg;

    ////////////////////////////////////////////////////////////////
    // hold wins only between accesses
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= BUS_IDLE;
        end else begin
            unique case (state_reg)
                BUS_IDLE: begin
                    if (hold_req)
                        state_reg <= BUS_HOLD;
                    else if (acc_req)
                        state_reg <= BUS_ACCESS;
                end
                BUS_ACCESS: begin
                    if (ready)
                        state_reg <= BUS_IDLE;
                end
                BUS_HOLD: begin
                    if (!hold_req)
                        state_reg <= BUS_IDLE;
                end
                default: state_reg <= BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rd_strobe_reg <= 1'b0;
            wr_strobe_reg <= 1'b0;
        end else if (state_reg == BUS_IDLE && !hold_req && acc_req) begin
            rd_strobe_reg <= !acc_write;
            wr_strobe_reg <= acc_write;
        end else if (state_reg == BUS_ACCESS && ready) begin
            rd_strobe_reg <= 1'b0;
            wr_strobe_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            bus_oe_reg   <= 1'b1;
            hold_ack_reg <= 1'b0;
        end else begin
            bus_oe_reg   <= !((state_reg == BUS_IDLE && hold_req) ||
                              (state_reg == BUS_HOLD && hold_req));
            hold_ack_reg <= (state_reg == BUS_IDLE && hold_req) ||
                            (state_reg == BUS_HOLD && hold_req);
        end
    end

    // completion pulse
    always_ff @(posedge clock) begin
        if (rst)
            acc_done_reg <= 1'b0;
        else
            acc_done_reg <= (state_reg == BUS_ACCESS) && ready;
    end

endmodule : cod_bus_ctrl

`default_nettype wire

/* File: cod_mem_model.sv */
// Purpose: memory and peripheral partner that answers strobes with ready
// Assumes: strobes are registered outputs of the decoder's bus control
// Notes:   wait count is set by the bench; ready is low between accesses
`default_nettype none

module cod_mem_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // strobes from the processor side
    input  wire logic       rd_strobe,
    input  wire logic       wr_strobe,
    // wait states for each access
    input  wire logic [3:0] wait_cycles,
    // answer to the processor
    output logic            ready
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////
    logic [3:0] wait_cnt_reg;

    // count waits while a strobe stands
    always_ff @(posedge clock) begin
        if (rst || !(rd_strobe || wr_strobe)) begin
            wait_cnt_reg <= 4'h0;
        end else if (wait_cnt_reg != wait_cycles) begin
            wait_cnt_reg <= wait_cnt_reg + 4'h1;
        end
    end

    // ready held low to stretch
    // no ready outside a strobe, so a design that ends early is caught
    assign ready = (rd_strobe || wr_strobe) && (wait_cnt_reg == wait_cycles);

endmodule : cod_mem_model

`default_nettype wire

/* File: cod_decode_tb_top.sv */
// Purpose: self-checking bench for the opcode decoder and bus control
// Assumes: partner model answers ready after a set number of waits
// Notes:   expected values come from the opcode map, never the design
`default_nettype none

`define CHK(nm, e, g) \
    begin \
        num_checks++; \
        if ((g) !== (e)) begin \
            errors++; \
            $display("Error %s expected %0h seen %0h", nm, e, g); \
        end \
    end

module cod_decode_tb_top
    import cod_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////
    logic        clock, rst, op_valid, acc_req, acc_write, ready, hold_req;
    logic [7:0]  opcode;
    cod_flags_s  flags;
    cod_decode_s dec_reg;
    logic        dec_valid_reg, rd_strobe_reg, wr_strobe_reg, bus_oe_reg;
    logic        hold_ack_reg, acc_done_reg;
    logic [3:0]  wait_cycles;
    int          errors, num_checks;

    // 50 MHz clock
    initial clock = 1'b0;
    always #10 clock = ~clock;

    cod_decode cod_decode_i (
        .clock(clock), .rst(rst), .op_valid(op_valid), .opcode(opcode),
        .flags(flags), .dec_valid_reg(dec_valid_reg), .dec_reg(dec_reg),
        .acc_req(acc_req), .acc_write(acc_write), .ready(ready),
        .hold_req(hold_req), .rd_strobe_reg(rd_strobe_reg),
        .wr_strobe_reg(wr_strobe_reg), .bus_oe_reg(bus_oe_reg),
        .hold_ack_reg(hold_ack_reg), .acc_done_reg(acc_done_reg));

    cod_mem_model cod_mem_model_i (
        .clock(clock), .rst(rst), .rd_strobe(rd_strobe_reg),
        .wr_strobe(wr_strobe_reg), .wait_cycles(wait_cycles), .ready(ready));

    ////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    // one opcode: valid pulses for one cycle, decode stays held after it
    task automatic dec(input logic [7:0] opc, input cod_flags_s f);
        @(posedge clock);
        op_valid <= 1'b1;
        opcode   <= opc;
        flags    <= f;
        @(posedge clock);
        op_valid <= 1'b0;
        @(negedge clock);
        `CHK("dec valid", 1'b1, dec_valid_reg)
        @(negedge clock);
        `CHK("dec pulse", 1'b0, dec_valid_reg)
    endtask : dec

    task automatic t_copy();
        logic [7:0] o;
        for (int i = 0; i < 64; i++) begin
            o = 8'h40 | 8'(i);
            if (o == 8'h76) continue;
            dec(o, '0);
            `CHK("copy op", OP_REG_COPY, dec_reg.op)
            `CHK("copy dst", o[5:3], dec_reg.dst)
            `CHK("copy src", o[2:0], dec_reg.src)
            `CHK("copy cyc", (o[5:3] == 3'h6 || o[2:0] == 3'h6) ? 5'h07 : 5'h04,
                 dec_reg.cycles)
        end
    endtask : t_copy

    task automatic t_alu();
        logic [7:0] o;
        for (int i = 0; i < 64; i++) begin
            o = 8'h80 | 8'(i);
            dec(o, '0);
            `CHK("alu op", OP_ALU_REG, dec_reg.op)
            `CHK("alu sel", o[5:3], dec_reg.alu)
            `CHK("alu cyc", (o[2:0] == 3'h6) ? 5'h07 : 5'h04, dec_reg.cycles)
            if (i < 8) begin
                o = 8'hc6 | 8'(i << 3);
                dec(o, '0);
                `CHK("imm op", OP_ALU_IMM, dec_reg.op)
                `CHK("imm sel", o[5:3], dec_reg.alu)
                `CHK("imm cyc", 5'h07, dec_reg.cycles)
            end
        end
    endtask : t_alu

    task automatic t_pair();
        logic [7:0] base [6] = '{8'h01, 8'h03, 8'h0b, 8'h09, 8'hc5, 8'hc1};
        cod_op_e    ops [6]  = '{OP_PAIR_IMM, OP_PAIR_INC, OP_PAIR_DEC,
                                 OP_PAIR_SUM, OP_PUSH, OP_POP};
        logic [4:0] cyc [6]  = '{5'h0a, 5'h06, 5'h06, 5'h0a, 5'h0c, 5'h0a};
        for (int p = 0; p < 4; p++) begin
            for (int j = 0; j < 6; j++) begin
                dec(base[j] | 8'(p << 4), '0);
                `CHK("pair op", ops[j], dec_reg.op)
                `CHK("pair sel", 2'(p), dec_reg.pair)
                `CHK("pair cyc", cyc[j], dec_reg.cycles)
                if (j > 3) `CHK("pair psw", p == 3, dec_reg.psw_sel)
            end
        end
    endtask : t_pair

    task automatic t_rot();
        for (int r = 0; r < 4; r++) begin
            dec(8'h07 | 8'(r << 3), '0);
            `CHK("rot op", OP_ROTATE, dec_reg.op)
            `CHK("rot sel", 2'(r), dec_reg.rot)
            `CHK("rot cyc", 5'h04, dec_reg.cycles)
        end
    endtask : t_rot

    task automatic t_misc();
        logic [7:0] opc [8] = '{8'he3, 8'hf9, 8'heb, 8'hc3, 8'hcd, 8'hc9, 8'he9, 8'h76};
        cod_op_e    ops [8] = '{OP_STK_HL_SWAP, OP_HL_TO_SP, OP_DE_HL_SWAP, OP_JUMP,
                                OP_CALL, OP_RETURN, OP_HL_TO_PC, OP_NONE};
        logic [4:0] cyc [8] = '{5'h10, 5'h06, 5'h04, 5'h0a, 5'h12, 5'h0a, 5'h06, 5'h00};
        for (int j = 0; j < 8; j++) begin
            dec(opc[j], '0);
            `CHK("fix op", ops[j], dec_reg.op)
            `CHK("fix cyc", cyc[j], dec_reg.cycles)
        end
        for (int a = 0; a < 8; a++) begin
            dec(8'hc7 | 8'(a << 3), '0);
            `CHK("rst op", OP_RESTART, dec_reg.op)
            `CHK("rst cyc", 5'h0c, dec_reg.cycles)
            `CHK("rst push", 1'b1, dec_reg.push_pc)
            `CHK("rst vec", 16'(a * 8), dec_reg.vector)
        end
    endtask : t_misc

    // conditions against all-clear and all-set flags
    task automatic t_cond();
        logic [7:0] base [3]    = '{8'hc2, 8'hc4, 8'hc0};
        cod_op_e    ops [3]     = '{OP_JUMP, OP_CALL, OP_RETURN};
        logic [4:0] cyc_no [3]  = '{5'h07, 5'h09, 5'h06};
        logic [4:0] cyc_yes [3] = '{5'h0a, 5'h12, 5'h0c};
        logic       met;
        for (int c = 0; c < 8; c++) begin
            for (int k = 0; k < 6; k++) begin
                // all flags set meets the odd codes only
                met = (k > 2) ? c[0] : !c[0];
                dec(base[k % 3] | 8'(c << 3), (k > 2) ? 4'hf : 4'h0);
                `CHK("cnd op", ops[k % 3], dec_reg.op)
                `CHK("cnd fld", 3'(c), dec_reg.cond)
                `CHK("cnd taken", met, dec_reg.taken)
                `CHK("cnd used", 1'b1, dec_reg.cond_used)
                `CHK("cnd push", met && (k % 3 == 1), dec_reg.push_pc)
                `CHK("cnd cyc", met ? cyc_yes[k % 3] : cyc_no[k % 3],
                     dec_reg.cycles)
            end
        end
    endtask : t_cond

    // waits for the strobe to end; acc_req is held until ready is seen
    task automatic finish_acc(input logic wr, input logic [3:0] w, input logic drop);
        int width;
        width = 0;
        for (int n = 0; n < 40; n++) begin
            @(negedge clock);
            if (rd_strobe_reg || wr_strobe_reg) begin
                width++;
                `CHK("strobe kind", {~wr, wr}, {rd_strobe_reg, wr_strobe_reg})
                `CHK("no grant", 1'b0, hold_ack_reg)
                if (ready) break;
            end
        end
        @(posedge clock);
        if (drop) acc_req <= 1'b0;
        @(negedge clock);
        `CHK("strobe width", w + 1, width)
        `CHK("strobe off", 1'b0, rd_strobe_reg | wr_strobe_reg)
        `CHK("done", 1'b1, acc_done_reg)
    endtask : finish_acc

    task automatic bus(input logic wr, input logic [3:0] w);
        @(posedge clock);
        wait_cycles <= w;
        acc_req     <= 1'b1;
        acc_write   <= wr;
        finish_acc(wr, w, 1'b1);
    endtask : bus

    // reads and writes stretched by waits
    task automatic t_bus();
        bus(1'b0, 4'h0);
        bus(1'b1, 4'h0);
        bus(1'b0, 4'h1);
        bus(1'b1, 4'h3);
        bus(1'b0, 4'h7);
    endtask : t_bus

    // hold in mid access, then a request waiting through the hold
    task automatic t_hold();
        bus(1'b1, 4'h0);
        @(posedge clock);
        acc_req     <= 1'b1;
        acc_write   <= 1'b0;
        wait_cycles <= 4'h3;
        @(posedge clock);
        hold_req    <= 1'b1;
        finish_acc(1'b0, 4'h3, 1'b0);
        repeat (3) begin
            @(negedge clock);
            `CHK("held oe", 1'b0, bus_oe_reg)
            `CHK("held ack", 1'b1, hold_ack_reg)
            `CHK("held strobe", 1'b0, rd_strobe_reg)
        end
        @(posedge clock);
        hold_req <= 1'b0;
        @(posedge clock);
        @(negedge clock);
        `CHK("freed oe", 1'b1, bus_oe_reg)
        `CHK("freed ack", 1'b0, hold_ack_reg)
        finish_acc(1'b0, 4'h3, 1'b1);
    endtask : t_hold

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst         = 1'b1;
        op_valid    = 1'b0;
        opcode      = 8'h00;
        flags       = '0;
        acc_req     = 1'b0;
        acc_write   = 1'b0;
        hold_req    = 1'b0;
        wait_cycles = 4'h0;
        errors      = 0;
        num_checks  = 0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        `CHK("reset oe", 1'b1, bus_oe_reg)
        t_copy();
        t_alu();
        t_pair();
        t_rot();
        t_misc();
        t_cond();
        t_bus();
        t_hold();
        print_verdict();
    end

    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge clock);
        errors++;
        print_verdict();
    end

endmodule : cod_decode_tb_top

`default_nettype wire
